/* File: src/tsq_regs.sv */
/*
  Control/status and timer-limit registers of the trigger sequencer, with
  the command executor, step delay, watchdog and interrupt logic.
  Assumes an AXI4-Lite master on aclk, a synchronous trigger input and a
  command source that holds cmd_req until cmd_ready.
*/
`default_nettype none

// Summary of operation
// - The upper input trigger mode bit picks single level detection when set, edge detection when clear.
// - The lower mode bit clear runs the step delay after a wait command, set skips it.
// - The input trigger mode only affects the wait-high and wait-low commands.
// - The software trigger bit is only looked at by a control step command, and writing zero does nothing.
// - The timer zero limit is used only by the timer zero step command.
// - The timer one limit is used only by the timer one step command.
// - While enable and start are both set the timer limits are read-only and writes are dropped.

module tsq_regs
    import tsq_pkg::*;
#(
    parameter int unsigned WDT_CYC  = WDT_CYCLES,
    parameter int unsigned STEP_CYC = STEP_DLY_CYCLES
) (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // AXI4-Lite write address
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [4:0]      s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    // AXI4-Lite write response
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    output logic      [1:0]      s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    input  wire logic [4:0]      s_axi_araddr,
    // AXI4-Lite read data
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    output logic      [31:0]     s_axi_rdata,
    output logic      [1:0]      s_axi_rresp,
    // Commands and trigger
    input  wire tsq_cmd_req_type cmd_req,
    output logic                 cmd_ready,
    input  wire logic            trig_in,
    // Status
    output logic                 step_pulse,
    output logic                 irq
);

    tsq_regs_state_type q, d;

    logic             running;
    logic             accept;
    logic             waiting;
    logic             det_arm;
    logic             det_hit;
    logic             tmr_load;
    logic [15:0]      tmr_val;
    logic [15:0]      tmr_cnt;
    logic             tmr_zero;
    logic             dly_load;
    logic             dly_zero;
    logic             wdt_zero;
    logic             wdt_fire;
    logic             swt_take;
    logic             aw_hs;
    logic             w_hs;
    logic             ar_hs;
    logic             wr_go;
    logic [4:0]       wr_addr;
    logic [15:0]      wr_data;
    logic [1:0]       wr_strb;
    logic [15:0]      ctrl_rd;
    logic [15:0]      ctrl_wr;
    logic [IRQ_W-1:0] irq_ev;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] nw,
                                            input logic [1:0]  strb);
        merge16 = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
    endfunction

    function automatic logic addr_hit(input logic [4:0] a);
        addr_hit = (a == OFS_CTRL) || (a == OFS_T0LIM) || (a == OFS_T1LIM) ||
                   (a == OFS_ISTAT) || (a == OFS_IMASK);
    endfunction

    assign running = q.en && q.strt;
    assign accept  = cmd_req.valid && cmd_ready;
    assign waiting = (q.st == ST_WAIT_IN) || (q.st == ST_SWT);
    assign det_arm = running && (q.st == ST_WAIT_IN);
    assign aw_hs   = s_axi_awvalid && s_axi_awready;
    assign w_hs    = s_axi_wvalid && s_axi_wready;
    assign ar_hs   = s_axi_arvalid && s_axi_arready;
    assign wr_go   = (q.aw_got || aw_hs) && (q.w_got || w_hs);
    assign wr_addr = q.aw_got ? q.awaddr : s_axi_awaddr;
    assign wr_data = q.w_got ? q.wdata : s_axi_wdata[15:0];
    assign wr_strb = q.w_got ? q.wstrb : s_axi_wstrb[1:0];

    // Each timer limit reaches the counter only from its own command
    assign tmr_load = accept && ((cmd_req.op == CMD_TIMER0) || (cmd_req.op == CMD_TIMER1));
    assign tmr_val  = (cmd_req.op == CMD_TIMER0) ? q.t0lim : q.t1lim;
    assign dly_load = (q.st == ST_WAIT_IN) && det_hit && !q.itm[BIT_ITM_NODLY];
    assign wdt_fire = running && waiting && wdt_zero;
    assign swt_take = running && (q.st == ST_SWT) && q.swt;

    always_comb begin
        ctrl_rd                = READ_ZERO;
        ctrl_rd[BIT_EN]        = q.en;
        ctrl_rd[BIT_SWT]       = q.swt;
        ctrl_rd[BIT_IVIS]      = q.ivis;
        ctrl_rd[BIT_STRT]      = q.strt;
        ctrl_rd[BIT_WDTO]      = q.wdto;
        ctrl_rd[BIT_ITM_LEVEL] = q.itm[BIT_ITM_LEVEL];
        ctrl_rd[BIT_ITM_NODLY] = q.itm[BIT_ITM_NODLY];
    end

    assign ctrl_wr = merge16(ctrl_rd, wr_data, wr_strb);

    always_comb begin
        d      = q;
        d.step = 1'b0;

        // Sequencer
        unique case (q.st)
            ST_IDLE: begin
                if (accept) begin
                    d.want_hi = (cmd_req.op == CMD_WAIT_HIGH);
                    case (cmd_req.op)
                        CMD_WAIT_HIGH, CMD_WAIT_LOW: d.st = ST_WAIT_IN;
                        CMD_CTRL_STEP:               d.st = ST_SWT;
                        CMD_TIMER0, CMD_TIMER1:      d.st = ST_TIMER;
                        default:                     d.step = 1'b1;
                    endcase
                end
            end
            ST_WAIT_IN: begin
                if (det_hit) begin
                    if (q.itm[BIT_ITM_NODLY]) begin
                        d.st   = ST_IDLE;
                        d.step = 1'b1;
                    end else begin
                        d.st = ST_DELAY;
                    end
                end
            end
            ST_DELAY: begin
                if (dly_zero) begin
                    d.st   = ST_IDLE;
                    d.step = 1'b1;
                end
            end
            ST_SWT: begin
                if (q.swt) begin
                    d.st   = ST_IDLE;
                    d.step = 1'b1;
                end
            end
            ST_TIMER: begin
                if (tmr_zero) begin
                    d.st   = ST_IDLE;
                    d.step = 1'b1;
                end
            end
        endcase
        if (wdt_fire) begin
            d.st   = ST_IDLE;
            d.step = 1'b0;
        end
        // Clearing start abandons the command in flight
        if (!running) begin
            d.st   = ST_IDLE;
            d.step = 1'b0;
        end
        irq_ev          = '0;
        irq_ev[IRQ_STEP] = d.step;
        irq_ev[IRQ_WDT]  = wdt_fire;

        // Write channel
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (aw_hs) begin
            d.aw_got = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (w_hs) begin
            d.w_got = 1'b1;
            d.wdata = s_axi_wdata[15:0];
            d.wstrb = s_axi_wstrb[1:0];
        end
        if (wr_go) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = addr_hit(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end

        // Hardware clear first, so a software set in the same cycle survives
        if (swt_take) begin
            d.swt = 1'b0;
        end
        if (wr_go && (wr_addr == OFS_CTRL)) begin
            d.en   = ctrl_wr[BIT_EN];
            d.ivis = ctrl_wr[BIT_IVIS];
            d.strt = ctrl_wr[BIT_STRT];
            d.itm  = ctrl_wr[BIT_ITM_LEVEL:BIT_ITM_NODLY];
            if (wr_strb[1] && wr_data[BIT_SWT]) begin
                d.swt = 1'b1;
            end
            if (wr_strb[0] && !wr_data[BIT_WDTO]) begin
                d.wdto = 1'b0;
            end
        end
        if (wr_go && !running && (wr_addr == OFS_T0LIM)) begin
            d.t0lim = merge16(q.t0lim, wr_data, wr_strb);
        end
        if (wr_go && !running && (wr_addr == OFS_T1LIM)) begin
            d.t1lim = merge16(q.t1lim, wr_data, wr_strb);
        end
        if (wr_go && (wr_addr == OFS_IMASK)) begin
            d.imask = wr_strb[0] ? wr_data[IRQ_W-1:0] : q.imask;
        end
        d.istat = q.istat;
        if (wr_go && (wr_addr == OFS_ISTAT) && wr_strb[0]) begin
            d.istat = q.istat & ~wr_data[IRQ_W-1:0];
        end
        // Events win over a clear in the same cycle
        d.istat = d.istat | irq_ev;
        if (wdt_fire) begin
            d.wdto = 1'b1;
        end

        // Read channel
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (ar_hs) begin
            d.rvalid = 1'b1;
            d.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                OFS_CTRL:  d.rdata = ctrl_rd;
                OFS_T0LIM: d.rdata = q.ivis ? tmr_cnt : q.t0lim;
                OFS_T1LIM: d.rdata = q.ivis ? tmr_cnt : q.t1lim;
                OFS_ISTAT: d.rdata = {14'h0000, q.istat};
                OFS_IMASK: d.rdata = {14'h0000, q.imask};
                default:   d.rdata = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= REGS_RESET;
        end else begin
            q <= d;
        end
    end

    tsq_trig_detect u_detect (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .trig_in    (trig_in),
        .arm        (det_arm),
        .want_high  (q.want_hi),
        .level_mode (q.itm[BIT_ITM_LEVEL]),
        .hit        (det_hit)
    );

    tsq_down_counter #(.W(16)) u_timer (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .dec      (q.st == ST_TIMER),
        .cnt      (tmr_cnt),
        .zero     (tmr_zero)
    );

    tsq_down_counter #(.W(16)) u_delay (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (dly_load),
        .load_val (16'(STEP_CYC - 1)),
        .dec      (q.st == ST_DELAY),
        .cnt      (),
        .zero     (dly_zero)
    );

    // Reloaded whenever nothing waits, so each wait gets a full window
    tsq_down_counter #(.W(16)) u_wdt (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (!waiting),
        .load_val (16'(WDT_CYC - 1)),
        .dec      (waiting),
        .cnt      (),
        .zero     (wdt_zero)
    );

    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready  = !q.w_got && !q.bvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = {READ_ZERO, q.rdata};
    assign s_axi_rresp   = q.rresp;
    assign cmd_ready     = running && (q.st == ST_IDLE);
    assign step_pulse    = q.step;
    assign irq           = |(q.istat & q.imask);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wait_hit_s;
        running && (q.st == ST_WAIT_IN) && det_hit && !wdt_zero;
    endsequence

    AST_NO_DELAY: assert property (wait_hit_s ##0 q.itm[BIT_ITM_NODLY]
        |=> (q.st == ST_IDLE) && step_pulse)
        else $error("delay not skipped");
    AST_DELAY_RUN: assert property (wait_hit_s ##0 !q.itm[BIT_ITM_NODLY]
        |=> (q.st == ST_DELAY) && !step_pulse)
        else $error("step delay not entered");
    AST_ARM_ONLY_WAIT: assert property (det_arm |-> q.st == ST_WAIT_IN)
        else $error("detector armed outside a wait command");
    AST_SWT_HOLD: assert property (running && (q.st == ST_SWT) && !q.swt && !wdt_zero
        |=> q.st == ST_SWT)
        else $error("control step left without software trigger");
    AST_T0_LOAD: assert property (accept && (cmd_req.op == CMD_TIMER0)
        |=> tmr_cnt == $past(q.t0lim))
        else $error("timer zero not loaded from its limit");
    AST_T1_LOAD: assert property (accept && (cmd_req.op == CMD_TIMER1)
        |=> tmr_cnt == $past(q.t1lim))
        else $error("timer one not loaded from its limit");
    AST_LIM_LOCK: assert property (running && wr_go && (wr_addr == OFS_T0LIM)
        |=> $stable(q.t0lim))
        else $error("timer limit written while locked");
    AST_WDT_FLAG: assert property (wdt_fire |=> q.wdto && (q.st == ST_IDLE))
        else $error("watchdog expiry not flagged");

endmodule

`default_nettype wire

/* File: src/tsq_pkg.sv */
/*
  Shared constants and types of the trigger sequencer control registers.
  Assumes a 200 MHz system clock and an AXI4-Lite register bus with 32-bit data.
*/
`default_nettype none

package tsq_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_CTRL  = 5'h00;
    localparam logic [4:0] OFS_T0LIM = 5'h04;
    localparam logic [4:0] OFS_T1LIM = 5'h08;
    localparam logic [4:0] OFS_ISTAT = 5'h0C;
    localparam logic [4:0] OFS_IMASK = 5'h10;

    // Control/status field positions
    localparam int BIT_EN        = 15;
    localparam int BIT_SWT       = 10;
    localparam int BIT_IVIS      = 8;
    localparam int BIT_STRT      = 7;
    localparam int BIT_WDTO      = 6;
    localparam int BIT_ITM_LEVEL = 1;
    localparam int BIT_ITM_NODLY = 0;

    // Interrupt status and mask layout
    localparam int IRQ_STEP = 0;
    localparam int IRQ_WDT  = 1;
    localparam int IRQ_W    = 2;

    // Bus answers and reset values
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [15:0] READ_ZERO   = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_PS   = 5000;
    localparam int WDT_TIME_NS     = 10000;
    localparam int WDT_CYCLES      = (WDT_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int STEP_DLY_NS     = 40;
    localparam int STEP_DLY_CYCLES = (STEP_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [2:0] {
        CMD_CTRL_STEP,
        CMD_WAIT_HIGH,
        CMD_WAIT_LOW,
        CMD_TIMER0,
        CMD_TIMER1,
        CMD_NOP
    } tsq_cmd_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT_IN,
        ST_SWT,
        ST_TIMER,
        ST_DELAY
    } tsq_state_type;

    typedef struct packed {
        logic        valid;
        tsq_cmd_type op;
    } tsq_cmd_req_type;

    typedef struct packed {
        logic             en;
        logic             swt;
        logic             ivis;
        logic             strt;
        logic             wdto;
        logic [1:0]       itm;
        logic [15:0]      t0lim;
        logic [15:0]      t1lim;
        logic [IRQ_W-1:0] istat;
        logic [IRQ_W-1:0] imask;
        tsq_state_type    st;
        logic             want_hi;
        logic             step;
        logic             aw_got;
        logic             w_got;
        logic [4:0]       awaddr;
        logic [15:0]      wdata;
        logic [1:0]       wstrb;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             rvalid;
        logic [15:0]      rdata;
        logic [1:0]       rresp;
    } tsq_regs_state_type;

    localparam tsq_regs_state_type REGS_RESET = '0;

endpackage

`default_nettype wire

/* File: src/tsq_down_counter.sv */
/*
  Loadable down counter that stops at zero.
  Assumes a synchronous active-low reset on the same clock as its user.
*/
`default_nettype none

module tsq_down_counter
    import tsq_pkg::*;
#(
    parameter int unsigned W = 16
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         dec,
    // Status
    output logic      [W-1:0] cnt,
    output logic              zero
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } tsq_cnt_state_type;

    tsq_cnt_state_type q, d;

    always_comb begin
        d = q;
        if (load) begin
            d.cnt = load_val;
        end else if (dec && (q.cnt != '0)) begin
            d.cnt = q.cnt - W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign cnt  = q.cnt;
    assign zero = (q.cnt == '0);

endmodule

`default_nettype wire

/* File: src/tsq_trig_detect.sv */
/*
  Input trigger detector for the wait-high and wait-low commands.
  Assumes trig_in is already synchronous to aclk.
*/
`default_nettype none

module tsq_trig_detect
    import tsq_pkg::*;
(
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Trigger and mode
    input  wire logic trig_in,
    input  wire logic arm,
    input  wire logic want_high,
    input  wire logic level_mode,
    // Result
    output logic      hit
);

    typedef struct packed {
        logic prev;
    } tsq_det_state_type;

    tsq_det_state_type q, d;

    always_comb begin
        d      = q;
        // Sampled always, so an edge right at arming is seen
        d.prev = trig_in;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Level mode fires on the level alone, edge mode needs a change
    assign hit = arm && (trig_in == want_high) && (level_mode || (q.prev != want_high));

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_LEVEL_HIT: assert property (arm && level_mode && (trig_in == want_high) |-> hit)
        else $error("level mode missed a matching level");
    AST_EDGE_ONLY: assert property (hit && !level_mode |-> $past(trig_in) != want_high)
        else $error("edge mode fired without an edge");

endmodule

`default_nettype wire

/* File: test/tsq_regs_tb.sv */
/*
  Self-checking bench for the trigger sequencer control registers.
  Assumes tsq_pkg and tsq_regs are compiled first; the bench is the bus master.
*/
`default_nettype none

module tsq_regs_tb
    import tsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // Shortened counts keep the run brief
    localparam int STEP_T = 4;
    localparam int WDT_T  = 20;

    logic            aclk;
    logic            aresetn;
    logic            s_axi_awvalid;
    logic            s_axi_awready;
    logic [4:0]      s_axi_awaddr;
    logic            s_axi_wvalid;
    logic            s_axi_wready;
    logic [31:0]     s_axi_wdata;
    logic [3:0]      s_axi_wstrb;
    logic            s_axi_bvalid;
    logic            s_axi_bready;
    logic [1:0]      s_axi_bresp;
    logic            s_axi_arvalid;
    logic            s_axi_arready;
    logic [4:0]      s_axi_araddr;
    logic            s_axi_rvalid;
    logic            s_axi_rready;
    logic [31:0]     s_axi_rdata;
    logic [1:0]      s_axi_rresp;
    tsq_cmd_req_type cmd_req;
    logic            cmd_ready;
    logic            trig_in;
    logic            step_pulse;
    logic            irq;
    int              error_cnt;
    int              checks_done;
    logic [1:0]      itm_tab [4];

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    tsq_regs #(.WDT_CYC(WDT_T), .STEP_CYC(STEP_T)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .cmd_req(cmd_req), .cmd_ready(cmd_ready), .trig_in(trig_in),
        .step_pulse(step_pulse), .irq(irq)
    );

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            error_cnt++;
        end
    endtask

    // Bready is raised with the request, so the answer is taken on its first edge
    task automatic axi_write(input logic [4:0] a, input logic [15:0] d, input logic [1:0] s,
                             output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= {16'hA5A5, d};
        s_axi_wstrb <= {2'b11, s};
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [1:0] r;
        axi_write(a, d, 2'b11, r);
        check("write resp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] e, input string nm);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(nm, d, e);
        check("read resp", {30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    task automatic issue_cmd(input tsq_cmd_type op);
        cmd_req <= '{valid: 1'b1, op: op};
        do @(posedge aclk); while (cmd_ready !== 1'b1);
        cmd_req.valid <= 1'b0;
    endtask

    // Counts edges from the current one; a pulse in cycle k is seen at n = k
    task automatic wait_pulse(input int lim, output int n, output logic got);
        n = 0;
        got = 1'b0;
        while (!got && n < lim) begin
            @(posedge aclk);
            n++;
            got = (step_pulse === 1'b1);
        end
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        print_verdict();
    end

    initial begin : main
        logic [31:0] d;
        logic [1:0]  r;
        int          n;
        logic        got;
        error_cnt = 0;
        checks_done = 0;
        itm_tab = '{2'b11, 2'b10, 2'b01, 2'b00};
        aresetn = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_awaddr = 5'h00;
        s_axi_wvalid = 1'b0;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'h0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_araddr = 5'h00;
        s_axi_rready = 1'b0;
        cmd_req = '0;
        trig_in = 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);

        rd_chk(OFS_CTRL, 32'h0000_0000, "ctrl reset");
        rd_chk(OFS_T0LIM, 32'h0000_0000, "t0lim reset");
        rd_chk(OFS_T1LIM, 32'h0000_0000, "t1lim reset");
        rd_chk(OFS_ISTAT, 32'h0000_0000, "istat reset");
        rd_chk(OFS_IMASK, 32'h0000_0000, "imask reset");
        axi_read(5'h14, d, r);
        check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        check("unmapped data", d, 32'h0000_0000);
        $display("test reset done");

        axi_write(OFS_T0LIM, 16'hFF05, 2'b01, r);
        rd_chk(OFS_T0LIM, 32'h0000_0005, "t0lim byte");
        wr(OFS_T1LIM, 16'h0009);
        rd_chk(OFS_T1LIM, 32'h0000_0009, "t1lim");
        wr(OFS_CTRL, 16'h0400);
        wr(OFS_CTRL, 16'h0000);
        rd_chk(OFS_CTRL, 32'h0000_0400, "swt write zero");
        $display("test access done");

        wr(OFS_CTRL, 16'h8080);
        rd_chk(OFS_CTRL, 32'h0000_8480, "ctrl running");
        wr(OFS_T0LIM, 16'h0777);
        rd_chk(OFS_T0LIM, 32'h0000_0005, "t0lim locked");
        issue_cmd(CMD_CTRL_STEP);
        wait_pulse(10, n, got);
        check("ctrl step pulse", {31'h0, got}, 32'h0000_0001);
        rd_chk(OFS_CTRL, 32'h0000_8080, "swt consumed");
        issue_cmd(CMD_CTRL_STEP);
        wait_pulse(4, n, got);
        check("ctrl step holds", {31'h0, got}, 32'h0000_0000);
        wr(OFS_CTRL, 16'h8480);
        rd_chk(OFS_CTRL, 32'h0000_8080, "late swt consumed");
        issue_cmd(CMD_NOP);
        wait_pulse(10, n, got);
        check("nop cycles", 32'(n), 32'd1);
        issue_cmd(CMD_TIMER0);
        wait_pulse(40, n, got);
        check("timer0 cycles", 32'(n), 32'd7);
        issue_cmd(CMD_TIMER1);
        wait_pulse(40, n, got);
        check("timer1 cycles", 32'(n), 32'd11);
        $display("test commands done");

        // Trigger raised mid-wait, so edge and level modes must both fire
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, {14'h2020, itm_tab[i]});
            issue_cmd(CMD_WAIT_HIGH);
            repeat (3) @(posedge aclk);
            trig_in <= 1'b1;
            wait_pulse(20, n, got);
            check("wait high cycles", 32'(n), itm_tab[i][0] ? 32'd2 : 32'(2 + STEP_T));
            trig_in <= 1'b0;
            @(posedge aclk);
        end
        wr(OFS_CTRL, 16'h8081);
        issue_cmd(CMD_WAIT_LOW);
        wait_pulse(6, n, got);
        check("edge mode idle", {31'h0, got}, 32'h0000_0000);
        trig_in <= 1'b1;
        repeat (2) @(posedge aclk);
        trig_in <= 1'b0;
        wait_pulse(20, n, got);
        check("wait low edge", 32'(n), 32'd2);
        wr(OFS_CTRL, 16'h8083);
        issue_cmd(CMD_WAIT_LOW);
        wait_pulse(10, n, got);
        check("level mode fires", {31'h0, got}, 32'h0000_0001);
        $display("test trigger modes done");

        wr(OFS_ISTAT, 16'h0003);
        issue_cmd(CMD_WAIT_HIGH);
        wait_pulse(2 * WDT_T, n, got);
        check("no pulse on expiry", {31'h0, got}, 32'h0000_0000);
        rd_chk(OFS_CTRL, 32'h0000_80C3, "wdto flag");
        rd_chk(OFS_ISTAT, 32'h0000_0002, "istat wdt");
        check("irq masked", {31'h0, irq}, 32'h0000_0000);
        wr(OFS_IMASK, 16'h0002);
        check("irq raised", {31'h0, irq}, 32'h0000_0001);
        wr(OFS_ISTAT, 16'h0002);
        check("irq cleared", {31'h0, irq}, 32'h0000_0000);
        $display("test watchdog done");

        wr(OFS_CTRL, 16'h0000);
        check("ready stopped", {31'h0, cmd_ready}, 32'h0000_0000);
        wr(OFS_T0LIM, 16'h0777);
        rd_chk(OFS_T0LIM, 32'h0000_0777, "t0lim unlocked");
        wr(OFS_CTRL, 16'h0100);
        rd_chk(OFS_CTRL, 32'h0000_0100, "wdto cleared");
        rd_chk(OFS_T1LIM, 32'h0000_0000, "t1 count visible");
        $display("test stop done");
        print_verdict();
    end

endmodule

`default_nettype wire
